// *** logic/cap_sense_defs.vh ***
// Register map, field layout and codes of the capacitance converter control
// ==========================================================================
// Behaviour
// R1: Mode 000 starts on each busy-bit write.
// R2: Modes 001-100 start on timer overflows.
// R3: Mode 110 converts continuously after busy write.
// R4: Mode 111 auto-scans continuously after busy write.
// R5: Accumulate 1/4/8/16/32/64 samples; 11x reserved.
// R6: 16-bit last result, two read-only bytes, reset zero.
// R7: Scan-first field names first auto-scan channel.
// R8: Scan-first write in auto-scan loads mux.
// R9: Scan-last field names last auto-scan channel.
// R10: Unused bits read zero, writes ignored.
// R11: Busy write starts only in 000/110/111.
// R12: Completion sets done flag; only software clears.
// R13: Auto-scan steps mux, wraps last to first.
// R14: Reserved codes start nothing, keep result.
`ifndef CAP_SENSE_DEFS_VH
`define CAP_SENSE_DEFS_VH

// ==========================================================================
// Register offsets
`define CS_ADDR_SCAN_FIRST   8'h92
`define CS_ADDR_SCAN_LAST    8'h93
`define CS_ADDR_CONFIG       8'h9E
`define CS_ADDR_RESULT_LOW   8'hA9
`define CS_ADDR_RESULT_HIGH  8'hAA

// ==========================================================================
// Field positions
`define CS_TRIG_MSB          6
`define CS_TRIG_LSB          4
`define CS_ACCUM_MSB         2
`define CS_ACCUM_LSB         0
`define CS_CHAN_MSB          5

// ==========================================================================
// Reset values
`define CS_RST_CONFIG        7'h00
`define CS_RST_CHAN          6'h00
`define CS_RST_RESULT        16'h0000

// ==========================================================================
// Trigger-select codes
`define CS_TRIG_SOFT         3'h0
`define CS_TRIG_TMR0         3'h1
`define CS_TRIG_TMR2         3'h2
`define CS_TRIG_TMR1         3'h3
`define CS_TRIG_TMR3         3'h4
`define CS_TRIG_RSVD         3'h5
`define CS_TRIG_CONT         3'h6
`define CS_TRIG_SCAN         3'h7

// ==========================================================================
// Accumulate-select codes and sample counts
`define CS_ACC_1             3'h0
`define CS_ACC_4             3'h1
`define CS_ACC_8             3'h2
`define CS_ACC_16            3'h3
`define CS_ACC_32            3'h4
`define CS_ACC_64            3'h5
`define CS_ACC_MAX_LEGAL     3'h5

`endif

// *** logic/cap_sense_config_scan_result.v ***
// Trigger, accumulate, result and auto-scan control of the capacitance converter
`timescale 1ns/1ps
`default_nettype none
`include "cap_sense_defs.vh"

module cap_sense_config_scan_result (
	// Clock and reset
	input  wire        sys_clk_in,
	input  wire        sys_rst_in,
	// Special-function register port
	input  wire [7:0]  sfr_addr_in,
	input  wire [7:0]  sfr_wdata_in,
	input  wire        sfr_wr_in,
	output reg  [7:0]  sfr_rdata_out,
	// Control register hooks
	input  wire        busy_write_one_in,
	input  wire        done_flag_clear_in,
	output reg         convert_busy_bit_out,
	output reg         conversion_done_flag_out,
	// Timer overflow pulses
	input  wire        timer0_overflow_in,
	input  wire        timer1_overflow_in,
	input  wire        timer2_overflow_in,
	input  wire        timer3_overflow_in,
	// Channel mux select register
	input  wire        mux_wr_in,
	input  wire [5:0]  mux_wdata_in,
	output reg  [5:0]  channel_mux_select_out,
	// Analog sampling core
	input  wire        sample_valid_in,
	input  wire [15:0] sample_data_in,
	output reg         sample_start_out
);

	// ==================================================================
	// States
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_REQ  = 2'b01;
	localparam [1:0] ST_WAIT = 2'b10;

	// ==================================================================
	// Registers
	reg  [2:0]  conversion_trigger_select_r;
	reg  [2:0]  sample_accumulate_select_r;
	reg  [5:0]  scan_first_channel_r;
	reg  [5:0]  scan_last_channel_r;
	reg  [15:0] result_r;
	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg  [21:0] accum_r;
	reg  [6:0]  sample_cnt_r;
	wire [6:0]  cfg_reset_val = `CS_RST_CONFIG;

	// ==================================================================
	// Decode
	wire wr_config = sfr_wr_in && (sfr_addr_in == `CS_ADDR_CONFIG);
	wire wr_first  = sfr_wr_in && (sfr_addr_in == `CS_ADDR_SCAN_FIRST);
	wire wr_last   = sfr_wr_in && (sfr_addr_in == `CS_ADDR_SCAN_LAST);

	wire [2:0] trig = conversion_trigger_select_r;
	wire [2:0] acu  = sample_accumulate_select_r;

	wire trig_rsvd  = (trig == `CS_TRIG_RSVD);                   // R14
	wire acu_rsvd   = (acu > `CS_ACC_MAX_LEGAL);                 // R14
	wire cfg_legal  = !trig_rsvd && !acu_rsvd;                   // R14
	wire auto_scan  = (trig == `CS_TRIG_SCAN);                   // R4
	wire continuous = (trig == `CS_TRIG_CONT) || auto_scan;      // R3 R4

	// Busy-bit writes only count in these three modes
	wire soft_start = busy_write_one_in && ((trig == `CS_TRIG_SOFT) ||
		continuous);                                             // R1 R11

	reg timer_start;
	always @* begin
		case (trig)
			`CS_TRIG_TMR0: timer_start = timer0_overflow_in;     // R2
			`CS_TRIG_TMR2: timer_start = timer2_overflow_in;     // R2
			`CS_TRIG_TMR1: timer_start = timer1_overflow_in;     // R2
			`CS_TRIG_TMR3: timer_start = timer3_overflow_in;     // R2
			default:       timer_start = 1'b0;
		endcase
	end

	// Starts arriving while busy are dropped, not queued
	wire start_req = cfg_legal && (soft_start || timer_start);

	reg [6:0] sample_target;
	always @* begin
		case (acu)
			`CS_ACC_1:  sample_target = 7'h01;                    // R5
			`CS_ACC_4:  sample_target = 7'h04;                    // R5
			`CS_ACC_8:  sample_target = 7'h08;                    // R5
			`CS_ACC_16: sample_target = 7'h10;                    // R5
			`CS_ACC_32: sample_target = 7'h20;                    // R5
			`CS_ACC_64: sample_target = 7'h40;                    // R5
			default:    sample_target = 7'h01;
		endcase
	end

	// ==================================================================
	// Accumulation
	wire [21:0] accum_sum = accum_r + {6'h00, sample_data_in};
	wire        last_sample = sample_valid_in && (state_r == ST_WAIT) &&
		((sample_cnt_r + 7'h01) == sample_target);
	// A reserved code at completion discards the conversion
	wire        complete = last_sample && cfg_legal;             // R14
	// Sums beyond 16 bits clip rather than wrap
	wire [15:0] accum_clip = (accum_sum[21:16] != 6'h00) ? 16'hFFFF :
		accum_sum[15:0];

	// ==================================================================
	// Sequencer
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_req)
					state_nxt = ST_REQ;
			end
			ST_REQ: begin
				state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (sample_valid_in) begin
					if (last_sample) begin
						if (complete && continuous)
							state_nxt = ST_REQ;                  // R3 R4
						else
							state_nxt = ST_IDLE;
					end else if (!cfg_legal) begin
						state_nxt = ST_IDLE;                     // R14
					end else begin
						state_nxt = ST_REQ;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_r          <= ST_IDLE;
			accum_r          <= 22'h000000;
			sample_cnt_r     <= 7'h00;
			sample_start_out <= 1'b0;
		end else begin
			state_r          <= state_nxt;
			sample_start_out <= (state_nxt == ST_REQ);
			if (state_r == ST_IDLE) begin
				accum_r      <= 22'h000000;
				sample_cnt_r <= 7'h00;
			end else if (sample_valid_in && state_r == ST_WAIT) begin
				if (last_sample) begin
					accum_r      <= 22'h000000;
					sample_cnt_r <= 7'h00;
				end else begin
					accum_r      <= accum_sum;                   // R5
					sample_cnt_r <= sample_cnt_r + 7'h01;
				end
			end
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in)
			convert_busy_bit_out <= 1'b0;
		else
			convert_busy_bit_out <= (state_nxt != ST_IDLE);      // R11
	end

	// ==================================================================
	// Result and done flag
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			result_r <= `CS_RST_RESULT;                          // R6
		end else if (complete) begin
			result_r <= accum_clip;                              // R6
		end
	end

	// Set wins over a software clear in the same cycle
	always @(posedge sys_clk_in) begin
		if (sys_rst_in)
			conversion_done_flag_out <= 1'b0;
		else if (complete)
			conversion_done_flag_out <= 1'b1;                    // R12
		else if (done_flag_clear_in)
			conversion_done_flag_out <= 1'b0;                    // R12
	end

	// ==================================================================
	// Configuration and scan range
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			conversion_trigger_select_r <=
				cfg_reset_val[`CS_TRIG_MSB:`CS_TRIG_LSB];
			sample_accumulate_select_r  <=
				cfg_reset_val[`CS_ACCUM_MSB:`CS_ACCUM_LSB];
			scan_first_channel_r        <= `CS_RST_CHAN;
			scan_last_channel_r         <= `CS_RST_CHAN;
		end else begin
			if (wr_config) begin
				conversion_trigger_select_r <=
					sfr_wdata_in[`CS_TRIG_MSB:`CS_TRIG_LSB];
				sample_accumulate_select_r  <=
					sfr_wdata_in[`CS_ACCUM_MSB:`CS_ACCUM_LSB];   // R10
			end
			if (wr_first)
				scan_first_channel_r <= sfr_wdata_in[`CS_CHAN_MSB:0]; // R7
			if (wr_last)
				scan_last_channel_r  <= sfr_wdata_in[`CS_CHAN_MSB:0]; // R9
		end
	end

	// ==================================================================
	// Mux select
	// Channels past the last one still wrap: a first above last walks
	// through the top of the channel space before returning.
	wire [5:0] mux_step = (channel_mux_select_out == scan_last_channel_r) ?
		scan_first_channel_r : channel_mux_select_out + 6'h01;

	always @(posedge sys_clk_in) begin
		if (sys_rst_in)
			channel_mux_select_out <= `CS_RST_CHAN;
		else if (wr_first && auto_scan)
			channel_mux_select_out <= sfr_wdata_in[`CS_CHAN_MSB:0]; // R8
		else if (mux_wr_in)
			channel_mux_select_out <= mux_wdata_in;
		else if (complete && auto_scan)
			channel_mux_select_out <= mux_step;                  // R13
	end

	// ==================================================================
	// Read path, one cycle behind the address
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sfr_rdata_out <= 8'h00;
		end else begin
			case (sfr_addr_in)
				`CS_ADDR_SCAN_FIRST:
					sfr_rdata_out <= {2'b00, scan_first_channel_r};   // R10
				`CS_ADDR_SCAN_LAST:
					sfr_rdata_out <= {2'b00, scan_last_channel_r};    // R10
				`CS_ADDR_CONFIG:
					sfr_rdata_out <= {1'b0, conversion_trigger_select_r,
						1'b0, sample_accumulate_select_r};            // R10
				`CS_ADDR_RESULT_LOW:
					sfr_rdata_out <= result_r[7:0];                  // R6
				`CS_ADDR_RESULT_HIGH:
					sfr_rdata_out <= result_r[15:8];                 // R6
				default:
					sfr_rdata_out <= 8'h00;
			endcase
		end
	end

endmodule // cap_sense_config_scan_result
`default_nettype wire

// *** dv/cap_sense_config_scan_result_chk.sv ***
// Assertion checker for the capacitance converter control block
`timescale 1ns/1ps
`default_nettype none
module cap_sense_config_scan_result_chk (
	// Watched ports
	input wire logic       sys_clk_in,
	input wire logic       sys_rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic       sfr_wr_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       busy_write_one_in,
	input wire logic       done_flag_clear_in,
	input wire logic       convert_busy_bit_out,
	input wire logic       conversion_done_flag_out,
	input wire logic       timer0_overflow_in,
	input wire logic       timer1_overflow_in,
	input wire logic       timer2_overflow_in,
	input wire logic       timer3_overflow_in,
	input wire logic [5:0] channel_mux_select_out,
	input wire logic       sample_start_out
);
	// ==================================================================
	// Shadow of the configuration, rebuilt from bus writes
	logic [6:0] cfg_r;
	wire  [2:0] trg  = cfg_r[6:4];
	wire        rsv  = trg == 3'h5 || cfg_r[2:1] == 2'b11;
	wire        idle = !convert_busy_bit_out;
	wire        tmr  = (trg == 3'h1 && timer0_overflow_in) ||
		(trg == 3'h2 && timer2_overflow_in) ||
		(trg == 3'h3 && timer1_overflow_in) ||
		(trg == 3'h4 && timer3_overflow_in);
	always @(posedge sys_clk_in) begin
		if (sys_rst_in)
			cfg_r <= 7'h00;
		else if (sfr_wr_in && sfr_addr_in == 8'h9E)
			cfg_r <= sfr_wdata_in[6:0];
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_soft_start: assert property (
		busy_write_one_in && idle && !rsv && (trg == 3'h0 || trg >= 3'h6)
		|=> sample_start_out && convert_busy_bit_out) else $error("no start");
	a_timer_start: assert property (
		tmr && idle && !rsv |=> sample_start_out) else $error("no timer start");
	a_busy_ignored: assert property (
		busy_write_one_in && !tmr && idle && trg >= 3'h1 && trg <= 3'h4
		|=> !sample_start_out) else $error("start in timer mode");
	a_no_rsv_start: assert property (
		rsv |=> !sample_start_out) else $error("start with reserved code");
	a_start_pulse: assert property (
		sample_start_out |-> convert_busy_bit_out ##1 !sample_start_out)
		else $error("start pulse bad");
	a_done_sticky: assert property (
		conversion_done_flag_out && !done_flag_clear_in
		|=> conversion_done_flag_out) else $error("done cleared");
	a_cfg_read: assert property (
		$past(sfr_addr_in) == 8'h9E |-> sfr_rdata_out ==
		{1'b0, $past(cfg_r[6:4]), 1'b0, $past(cfg_r[2:0])})
		else $error("config read bad");
	a_chan_read: assert property (
		$past(sfr_addr_in) inside {8'h92, 8'h93} |-> sfr_rdata_out[7:6] == 2'b00)
		else $error("channel upper bits set");
	a_unmapped_zero: assert property (
		!($past(sfr_addr_in) inside {8'h92, 8'h93, 8'h9E, 8'hA9, 8'hAA})
		|-> sfr_rdata_out == 8'h00) else $error("unmapped read nonzero");
	a_scan_mux: assert property (
		sfr_wr_in && sfr_addr_in == 8'h92 && trg == 3'h7 |=>
		{2'b00, channel_mux_select_out} == ($past(sfr_wdata_in) & 8'h3F))
		else $error("mux not loaded");
endmodule // cap_sense_config_scan_result_chk
`default_nettype wire

// *** dv/cap_sense_config_scan_result_bench.sv ***
// Self-checking bench for the capacitance converter control block
`timescale 1ns/1ps
`default_nettype none
module cap_sense_config_scan_result_bench;
	// ==================================================================
	// Stimulus, observed outputs and model state
	logic        sys_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [7:0]  sfr_addr_in = 8'h00;
	logic [7:0]  sfr_wdata_in = 8'h00;
	logic        sfr_wr_in = 1'b0;
	logic        busy_write_one_in = 1'b0;
	logic        done_flag_clear_in = 1'b0;
	logic [3:0]  tmr = 4'h0;
	logic        mux_wr_in = 1'b0;
	logic [5:0]  mux_wdata_in = 6'h00;
	logic        sample_valid_in = 1'b0;
	logic [15:0] sample_data_in = 16'h0000;
	wire  [7:0]  sfr_rdata_out;
	wire         convert_busy_bit_out;
	wire         conversion_done_flag_out;
	wire         sample_start_out;
	wire  [5:0]  channel_mux_select_out;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          exp_res = 0;
	int          ch = 0;
	int          cnt [6] = '{1, 4, 8, 16, 32, 64};
	int          tsel [4] = '{0, 2, 1, 3};
	logic [7:0]  addrs [6] = '{8'h92, 8'h93, 8'h9E, 8'hA9, 8'hAA, 8'h50};
	cap_sense_config_scan_result dut_u (.sys_clk_in, .sys_rst_in,
		.sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rdata_out,
		.busy_write_one_in, .done_flag_clear_in, .convert_busy_bit_out,
		.conversion_done_flag_out, .timer0_overflow_in(tmr[0]),
		.timer1_overflow_in(tmr[1]), .timer2_overflow_in(tmr[2]),
		.timer3_overflow_in(tmr[3]), .mux_wr_in, .mux_wdata_in,
		.channel_mux_select_out, .sample_valid_in, .sample_data_in,
		.sample_start_out);
	always #2.5 sys_clk_in = ~sys_clk_in;
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1'b1;
		cyc(1);
		sfr_wr_in = 1'b0;
		// Idle cycle so a following write always re-raises the strobe
		cyc(1);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr_in = a;
		cyc(1);
		chk("sfr read", {8'h00, e}, {8'h00, sfr_rdata_out});
	endtask
	// Index below 4 pulses that timer, otherwise a busy-bit write
	task kick(input int t);
		if (t < 4)
			tmr[t] = 1'b1;
		else
			busy_write_one_in = 1'b1;
		cyc(1);
		if (t < 4)
			tmr[t] = 1'b0;
		else
			busy_write_one_in = 1'b0;
	endtask
	// Stop switches to mode 000 mid-conversion so the run ends cleanly
	task conv(input int n, input bit stop);
		int k;
		int s;
		s = 0;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (sample_start_out !== 1'b1 && k < 40) begin
				cyc(1);
				k++;
			end
			chk("start", 1, sample_start_out);
			// A sample only counts once the request cycle is over
			if (stop && i == n - 1)
				wr(8'h9E, 8'h00);
			else
				cyc(1);
			sample_data_in = $urandom;
			sample_valid_in = 1'b1;
			s += sample_data_in;
			cyc(1);
			sample_valid_in = 1'b0;
		end
		exp_res = s > 65535 ? 65535 : s;
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		end_of_test;
	end
	initial begin
		void'($urandom(32'h9902));
		cyc(8);
		sys_rst_in = 1'b0;
		foreach (addrs[i]) rd(addrs[i], 8'h00);
		wr(8'h9E, 8'hFF);
		rd(8'h9E, 8'h77);
		wr(8'h92, 8'hFF);
		rd(8'h92, 8'h3F);
		chk("mux", 16'h003F, channel_mux_select_out);
		kick(4);
		cyc(3);
		chk("busy", 0, convert_busy_bit_out);
		for (int a = 0; a < 6; a++) begin
			wr(8'h9E, a[7:0]);
			kick(4);
			conv(cnt[a], 1'b0);
			chk("busy", 0, convert_busy_bit_out);
			rd(8'hAA, exp_res[15:8]);
			rd(8'hA9, exp_res[7:0]);
			chk("done", 1, conversion_done_flag_out);
			done_flag_clear_in = 1'b1;
			cyc(1);
			done_flag_clear_in = 1'b0;
			chk("done", 0, conversion_done_flag_out);
		end
		for (int t = 1; t < 5; t++) begin
			wr(8'h9E, {1'b0, t[2:0], 4'h0});
			kick(4);
			kick((tsel[t - 1] + 1) % 4);
			cyc(2);
			chk("busy", 0, convert_busy_bit_out);
			kick(tsel[t - 1]);
			conv(1, 1'b0);
			rd(8'hA9, exp_res[7:0]);
		end
		wr(8'h9E, 8'h50);
		for (int t = 0; t < 5; t++) begin
			kick(t);
			cyc(1);
		end
		cyc(2);
		chk("busy", 0, convert_busy_bit_out);
		rd(8'hA9, exp_res[7:0]);
		wr(8'h93, 8'hC5);
		rd(8'h93, 8'h05);
		mux_wdata_in = 6'h09;
		mux_wr_in = 1'b1;
		cyc(1);
		mux_wr_in = 1'b0;
		for (int m = 6; m < 8; m++) begin
			wr(8'h9E, {1'b0, m[2:0], 4'h0});
			wr(8'h92, 8'h03);
			ch = (m == 7) ? 3 : 9;
			chk("mux", ch, channel_mux_select_out);
			kick(4);
			for (int i = 0; i < 4; i++) begin
				conv(1, i == 3);
				if (m == 7) ch = (ch == 5) ? 3 : ch + 1;
				if (i < 3) chk("mux", ch, channel_mux_select_out);
				chk("busy", i < 3, convert_busy_bit_out);
			end
			rd(8'hA9, exp_res[7:0]);
		end
		end_of_test;
	end
endmodule // cap_sense_config_scan_result_bench
bind cap_sense_config_scan_result cap_sense_config_scan_result_chk chk_u (
	.sys_clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
	.sfr_rdata_out, .busy_write_one_in, .done_flag_clear_in,
	.convert_busy_bit_out, .conversion_done_flag_out, .timer0_overflow_in,
	.timer1_overflow_in, .timer2_overflow_in, .timer3_overflow_in,
	.channel_mux_select_out, .sample_start_out);
`default_nettype wire
